//--- logic/cdr_responder.sv
`timescale 1ns/1ps

// Contract
// - Emergency frames use identifier 80 hex plus node address.
// - SDO responses use identifier 580 hex plus node address.
// - Emergency, request and response frames all carry eight data bytes.
// - Module error emergency starts with error code, low byte first.
// - Third emergency byte holds the current error register value.
// - Fourth emergency byte is module index; diagnostic bytes follow.
// - Bit 6 of second diag byte reports short to high on output 4.
// - Bit 0 of fourth diag byte reports two-channel error on inputs 1-2.
// - Expedited upload answered with command 42 hex.
// - Current-error subindex selects module at position subindex minus one.
// - Current-error data active low; cleared bit 2 of fifth byte: external.
// - Current-error cleared bit 0 of fourth byte: two-channel error.
// - History subindex 01 returns latest error diagnostic bytes.
// - Configuration required or incomplete: module LED flashes red at 1 Hz.
// - No process-data transfer yet: module LED red/green, network LED green.
// - All errors removed: emergency with zero code, register and bytes.
module cdr_responder #(
	parameter int MODULES = 16,
	parameter int FLASH_HALF = cdr_pkg::FLASH_HALF_CYCLES
) (
	input wire logic clock,
	input wire logic reset,
	input wire logic [6:0] node_address,
	// Error event from the module bus, same clock domain.
	input wire logic err_event,
	input wire logic [7:0] err_module_index,
	input wire cdr_pkg::cdr_diag_t err_diag,
	input wire logic [7:0] err_register,
	input wire logic all_errors_cleared,
	// Current diagnostic state of each module, active-high error bits.
	input wire cdr_pkg::cdr_diag_t [MODULES-1:0] module_diag,
	// Received frame from the CAN controller.
	input wire logic rx_valid,
	input wire cdr_pkg::cdr_frame_t rx_frame,
	// Transmit port toward the CAN controller.
	input wire logic tx_ready,
	output cdr_pkg::cdr_frame_t tx_frame,
	output logic tx_valid,
	// Status inputs and LEDs.
	input wire logic config_pending,
	input wire logic pdo_seen,
	input wire logic bus_ok,
	output cdr_pkg::cdr_led_t module_status_led,
	output cdr_pkg::cdr_led_t network_status_led,
	output logic supply_indicator_led
);

	cdr_pkg::cdr_frame_t tx_frame_r;
	logic tx_valid_r;
	cdr_pkg::cdr_frame_t emcy_pend_r;
	logic emcy_pend_valid_r;
	cdr_pkg::cdr_frame_t sdo_pend_r;
	logic sdo_pend_valid_r;
	cdr_pkg::cdr_diag_t hist_diag_r;
	cdr_pkg::cdr_led_t mod_led_r;
	cdr_pkg::cdr_led_t net_led_r;
	logic supply_led_r;
	logic [31:0] flash_cnt_r;
	logic flash_phase_r;

	logic req_hit;
	logic [15:0] req_index;
	logic [7:0] req_sub;
	logic [7:0] module_pos;
	cdr_pkg::cdr_frame_t sdo_rsp;
	logic req_known;
	logic req_take;
	logic tx_free;

	// Builds an identifier from a function base and the node address.
	function automatic logic [10:0] make_id(input logic [10:0] base,
		input logic [6:0] node);
		make_id = base + {4'h0, node};
	endfunction : make_id

	// Places four diagnostic bytes into data bytes 4..7 of a frame.
	function automatic logic [31:0] diag_bytes(input cdr_pkg::cdr_diag_t d);
		diag_bytes = {d.diag_byte_five, d.diag_byte_four,
			d.diag_byte_three, d.diag_byte_two};
	endfunction : diag_bytes

	// Current-error read of a module that exists. Subindex 0 would wrap
	// to position 255, so it is refused before the array is touched.
	function automatic logic cur_err_hit(input logic [15:0] index,
		input logic [7:0] sub);
		logic [7:0] pos;
		pos = sub - cdr_pkg::SUB_MODULE_OFS;
		cur_err_hit = index == cdr_pkg::OBJ_CUR_ERR && sub != 8'h00
			&& 32'(pos) < 32'(MODULES);
	endfunction : cur_err_hit

	// Read of the latest entry of the error history.
	function automatic logic hist_hit(input logic [15:0] index,
		input logic [7:0] sub);
		hist_hit = index == cdr_pkg::OBJ_ERR_HIST
			&& sub == cdr_pkg::SUB_LAST_ERR;
	endfunction : hist_hit

	// Request decode: own address, eight bytes and upload command only.
	assign req_index = {rx_frame.data[2], rx_frame.data[1]};
	assign req_sub = rx_frame.data[3];
	assign module_pos = req_sub - cdr_pkg::SUB_MODULE_OFS;
	assign req_hit = rx_valid
		&& rx_frame.id == make_id(cdr_pkg::SDO_REQ_BASE, node_address)
		&& rx_frame.dlc == cdr_pkg::FRAME_DLC
		&& rx_frame.data[0] == cdr_pkg::CMD_UPLOAD_REQ;

	// Only objects that this responder can answer are taken; anything else
	// is dropped silently, as no abort frame is generated.
	assign req_known = cur_err_hit(req_index, req_sub)
		|| hist_hit(req_index, req_sub);
	assign req_take = req_hit && req_known;

	// The transmit register may load while empty or while being drained.
	assign tx_free = !tx_valid_r || tx_ready;

	// Response assembly; unknown objects or modules are not answered.
	always_comb
	begin
		sdo_rsp = '0;
		sdo_rsp.id = make_id(cdr_pkg::SDO_RSP_BASE, node_address);
		sdo_rsp.dlc = cdr_pkg::FRAME_DLC;
		sdo_rsp.data[0] = cdr_pkg::CMD_UPLOAD_RSP;
		sdo_rsp.data[1] = rx_frame.data[1];
		sdo_rsp.data[2] = rx_frame.data[2];
		sdo_rsp.data[3] = req_sub;
		if (cur_err_hit(req_index, req_sub))
		begin
			// Current errors are returned inverted: cleared bit means error.
			sdo_rsp.data[7:4] = ~diag_bytes(module_diag[module_pos]);
		end
		else if (hist_hit(req_index, req_sub))
		begin
			sdo_rsp.data[7:4] = diag_bytes(hist_diag_r);
		end
	end

	// Pending SDO answer; a new request overwrites an unsent one.
	// A single slot keeps the area small; a master that sends a second
	// request before the first answer has left loses the first answer.
	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			sdo_pend_r <= '0;
			sdo_pend_valid_r <= 1'b0;
		end
		else if (req_take)
		begin
			sdo_pend_r <= sdo_rsp;
			sdo_pend_valid_r <= 1'b1;
		end
		else if (sdo_pend_valid_r && !emcy_pend_valid_r && tx_free)
		begin
			sdo_pend_valid_r <= 1'b0;
		end
	end

	// Pending emergency frame and latest error history entry. A new error
	// wins over an all-clear in the same cycle, and a later error replaces
	// one that is still waiting, so only the newest emergency is kept.
	// The history keeps one entry, the one that subindex 01 returns.
	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			emcy_pend_r <= '0;
			emcy_pend_valid_r <= 1'b0;
			hist_diag_r <= '0;
		end
		else if (err_event)
		begin
			emcy_pend_r.id <= make_id(cdr_pkg::EMCY_ID_BASE, node_address);
			emcy_pend_r.dlc <= cdr_pkg::FRAME_DLC;
			emcy_pend_r.data[0] <= cdr_pkg::EMCY_MODULE_ERR[7:0];
			emcy_pend_r.data[1] <= cdr_pkg::EMCY_MODULE_ERR[15:8];
			emcy_pend_r.data[2] <= err_register;
			emcy_pend_r.data[3] <= err_module_index;
			// Short on Q4 and two-channel bits ride in their diag bytes.
			emcy_pend_r.data[7:4] <= diag_bytes(err_diag);
			emcy_pend_valid_r <= 1'b1;
			hist_diag_r <= err_diag;
		end
		else if (all_errors_cleared)
		begin
			emcy_pend_r.id <= make_id(cdr_pkg::EMCY_ID_BASE, node_address);
			emcy_pend_r.dlc <= cdr_pkg::FRAME_DLC;
			emcy_pend_r.data <= {48'h0, cdr_pkg::EMCY_NO_ERR};
			emcy_pend_valid_r <= 1'b1;
		end
		else if (emcy_pend_valid_r && tx_free)
		begin
			emcy_pend_valid_r <= 1'b0;
		end
	end

	// Transmit stage; emergencies take priority over SDO answers. A frame
	// stands with its valid until the controller takes it, so a stalled
	// bus holds every later answer back in the pending registers.
	// The cost of one slot per source is that a waiting answer is replaced.
	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			tx_frame_r <= '0;
			tx_valid_r <= 1'b0;
		end
		else if (tx_free)
		begin
			if (emcy_pend_valid_r)
			begin
				tx_frame_r <= emcy_pend_r;
				tx_valid_r <= 1'b1;
			end
			else if (sdo_pend_valid_r)
			begin
				tx_frame_r <= sdo_pend_r;
				tx_valid_r <= 1'b1;
			end
			else
			begin
				tx_valid_r <= 1'b0;
			end
		end
	end

	// Half-period counter for the 1 Hz flash.
	// A 32-bit count covers a slow half period at the full clock rate.
	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			flash_cnt_r <= '0;
			flash_phase_r <= 1'b0;
		end
		else if (flash_cnt_r == 32'(FLASH_HALF - 1))
		begin
			flash_cnt_r <= '0;
			flash_phase_r <= !flash_phase_r;
		end
		else
		begin
			flash_cnt_r <= flash_cnt_r + 32'h1;
		end
	end

	// The supply indicator is lit from the first cycle out of reset.
	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			supply_led_r <= 1'b0;
		end
		else
		begin
			supply_led_r <= 1'b1;
		end
	end

	// Network LED follows the bus state; green whenever the node is on line.
	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			net_led_r <= cdr_pkg::CDR_LED_OFF;
		end
		else
		begin
			net_led_r <= bus_ok ? cdr_pkg::CDR_LED_GREEN
				: cdr_pkg::CDR_LED_OFF;
		end
	end

	// Module LED; configuration outranks the missing process data, so a
	// node that is both unconfigured and idle shows the red flash only.
	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			mod_led_r <= cdr_pkg::CDR_LED_OFF;
		end
		else if (config_pending)
		begin
			mod_led_r <= flash_phase_r ? cdr_pkg::CDR_LED_RED
				: cdr_pkg::CDR_LED_OFF;
		end
		else if (!pdo_seen)
		begin
			// Red/green alternates on the same flash clock.
			mod_led_r <= flash_phase_r ? cdr_pkg::CDR_LED_RED
				: cdr_pkg::CDR_LED_GREEN;
		end
		else
		begin
			mod_led_r <= cdr_pkg::CDR_LED_GREEN;
		end
	end

	assign tx_frame = tx_frame_r;
	assign tx_valid = tx_valid_r;
	assign module_status_led = mod_led_r;
	assign network_status_led = net_led_r;
	assign supply_indicator_led = supply_led_r;

endmodule : cdr_responder

//--- logic/cdr_pkg.sv
package cdr_pkg;

	// Frame identifiers are a function base plus the node address.
	localparam logic [10:0] EMCY_ID_BASE = 11'h080;
	localparam logic [10:0] SDO_REQ_BASE = 11'h600;
	localparam logic [10:0] SDO_RSP_BASE = 11'h580;
	localparam logic [3:0] FRAME_DLC = 4'h8;

	// SDO command bytes.
	localparam logic [7:0] CMD_UPLOAD_REQ = 8'h40;
	localparam logic [7:0] CMD_UPLOAD_RSP = 8'h42;

	// Objects served by the responder.
	localparam logic [15:0] OBJ_CUR_ERR = 16'h3100;
	localparam logic [15:0] OBJ_ERR_HIST = 16'h1003;
	localparam logic [7:0] SUB_LAST_ERR = 8'h01;
	localparam logic [7:0] SUB_MODULE_OFS = 8'h01;

	// Emergency content.
	localparam logic [15:0] EMCY_MODULE_ERR = 16'hff03;
	localparam logic [15:0] EMCY_NO_ERR = 16'h0000;

	// Diagnostic bit positions inside the four module bytes.
	localparam int DIAG_SHORT_HIGH_Q4_BIT = 6;
	localparam int DIAG_TWO_CH_I12_BIT = 0;
	localparam int DIAG_EXT_ERR_BIT = 2;

	// Flash timing for the status LED.
	localparam int CLOCK_HZ = 125000000;
	localparam int FLASH_HZ = 1;
	localparam int FLASH_HALF_CYCLES = CLOCK_HZ / (2 * FLASH_HZ);
	localparam logic [7:0] RESET_BYTE = 8'h00;

	// One classic CAN data frame with eight bytes, byte 0 first.
	typedef struct packed {
		logic [10:0] id;
		logic [3:0] dlc;
		logic [7:0][7:0] data;
	} cdr_frame_t;

	// Four diagnostic bytes of a module, index 0 is the second diag byte.
	typedef struct packed {
		logic [7:0] diag_byte_five;
		logic [7:0] diag_byte_four;
		logic [7:0] diag_byte_three;
		logic [7:0] diag_byte_two;
	} cdr_diag_t;

	typedef enum logic [1:0] {
		CDR_LED_OFF,
		CDR_LED_RED,
		CDR_LED_GREEN
	} cdr_led_t;

endpackage : cdr_pkg

//--- verification/cdr_responder_asserts.sv
`timescale 1ns/1ps
// Ties the transmit side to the node address and the received requests.
module cdr_responder_asserts (
	input wire logic clock,
	input wire logic reset,
	input wire logic [6:0] node_address,
	input wire logic rx_valid,
	input wire cdr_pkg::cdr_frame_t rx_frame,
	input wire logic tx_ready,
	input wire cdr_pkg::cdr_frame_t tx_frame,
	input wire logic tx_valid
);
	logic [10:0] emcy_id, rsp_id, req_id;
	// Identifiers this node must use or accept.
	assign emcy_id = 11'h080 + {4'h0, node_address};
	assign rsp_id = 11'h580 + {4'h0, node_address};
	assign req_id = 11'h600 + {4'h0, node_address};
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (reset);
	hold_tx_a: assert property (
		tx_valid && !tx_ready |=> tx_valid && $stable(tx_frame))
		else $error("tx frame changed before accept");
	dlc_eight_a: assert property (tx_valid |-> tx_frame.dlc == 4'h8)
		else $error("tx dlc not eight");
	tx_ident_a: assert property (
		tx_valid |-> tx_frame.id == rsp_id || tx_frame.id == emcy_id)
		else $error("tx identifier wrong");
	rsp_cmd_a: assert property (
		tx_valid && tx_frame.id == rsp_id |-> tx_frame.data[0] == 8'h42)
		else $error("response command wrong");
	emcy_code_a: assert property (
		tx_valid && tx_frame.id == emcy_id && tx_frame.data[2] != 8'h00
		|-> {tx_frame.data[1], tx_frame.data[0]} == 16'hff03)
		else $error("emergency code wrong");
	emcy_clear_a: assert property (
		tx_valid && tx_frame.id == emcy_id && tx_frame.data[2] == 8'h00
		|-> tx_frame.data == 64'h0)
		else $error("clear emergency not zero");
	sdo_answer_a: assert property (
		rx_valid && !tx_valid && rx_frame.id == req_id
		&& rx_frame.dlc == 4'h8 && rx_frame.data[3:0] == 32'h01100340
		|-> ##[2:8] tx_valid && tx_frame.id == rsp_id)
		else $error("no history answer");
	foreign_a: assert property (
		rx_valid && rx_frame.id != req_id && !tx_valid && !$past(rx_valid)
		|-> ##2 !tx_valid)
		else $error("answered a foreign request");
endmodule : cdr_responder_asserts

bind cdr_responder cdr_responder_asserts u_chk (.clock, .reset, .node_address,
	.rx_valid, .rx_frame, .tx_ready, .tx_frame, .tx_valid);

//--- verification/cdr_master_model.sv
`timescale 1ns/1ps
// Master side: sends requests as one-cycle pulses and sinks every reply.
module cdr_master_model (
	input wire logic clock,
	input wire logic stall,
	input wire logic tx_valid,
	input wire cdr_pkg::cdr_frame_t tx_frame,
	output logic tx_ready,
	output logic rx_valid,
	output cdr_pkg::cdr_frame_t rx_frame
);
	int n_got = 0;
	cdr_pkg::cdr_frame_t last;
	assign tx_ready = !stall;
	initial rx_valid = 1'b0;
	initial rx_frame = '0;
	// Keeps the last accepted frame so the bench can judge it.
	always @(posedge clock)
	begin
		if (tx_valid && tx_ready)
		begin
			last <= tx_frame;
			n_got <= n_got + 1;
		end
	end
	// Requests carry id 600h plus node, eight bytes, command 40h
	task send(input cdr_pkg::cdr_frame_t f);
		@(posedge clock);
		#1;
		rx_frame = f;
		rx_valid = 1'b1;
		@(posedge clock);
		#1;
		rx_valid = 1'b0;
		rx_frame = ~f; // A released bus must not echo the old frame.
	endtask : send
endmodule : cdr_master_model

//--- verification/canopen_diag_responder_tb_top.sv
`timescale 1ns/1ps
module canopen_diag_responder_tb_top;
	logic clock = 0, reset = 1, err_event = 0, all_errors_cleared = 0;
	logic config_pending = 0, pdo_seen = 0, bus_ok = 1, stall = 0;
	logic rx_valid, tx_ready, tx_valid;
	logic [6:0] node_address = 7'h0c;
	logic [7:0] err_module_index = 0, err_register = 0;
	cdr_pkg::cdr_diag_t err_diag = '0;
	cdr_pkg::cdr_diag_t [15:0] module_diag = '0;
	cdr_pkg::cdr_frame_t rx_frame, tx_frame;
	cdr_pkg::cdr_led_t mod_led, net_led;
	logic supply_led;
	int n_fail = 0, tests_run = 0;
	// Short flash period so the LED scenario stays brief.
	cdr_responder #(.MODULES(16), .FLASH_HALF(4)) dut (.clock, .reset,
		.node_address, .err_event, .err_module_index, .err_diag, .err_register,
		.all_errors_cleared, .module_diag, .rx_valid, .rx_frame, .tx_ready,
		.tx_frame, .tx_valid, .config_pending, .pdo_seen, .bus_ok,
		.module_status_led(mod_led), .network_status_led(net_led),
		.supply_indicator_led(supply_led));
	cdr_master_model m (.clock, .stall, .tx_valid, .tx_frame, .tx_ready,
		.rx_valid, .rx_frame);
	initial forever #4 clock = ~clock;
	task step(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask : step
	task chk(input string what, input logic [74:0] exp, input logic [74:0] got);
		tests_run++;
		if (got !== exp)
		begin
			n_fail++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	// Bytes are written first to last, as they go on the wire.
	function cdr_pkg::cdr_frame_t fr(input logic [10:0] id, input logic [63:0] b);
		fr.id = id;
		fr.dlc = 4'h8;
		for (int i = 0; i < 8; i++)
			fr.data[i] = b[63-8*i -: 8];
	endfunction : fr
	// Bounded wait for one more accepted frame, then compares it.
	task expect_tx(input string what, input cdr_pkg::cdr_frame_t exp);
		int k;
		k = m.n_got;
		repeat (40) if (m.n_got == k) step(1);
		chk({what, " count"}, 75'(k + 1), 75'(m.n_got));
		chk(what, exp, m.last);
	endtask : expect_tx
	task ev_hist(input string w, input logic [7:0] idx, input logic [31:0] d,
		input logic [63:0] eb, input logic [63:0] hb);
		err_module_index = idx;
		err_diag = d;
		err_register = 8'h01;
		err_event = 1;
		step(1);
		err_event = 0;
		expect_tx({w, " emcy"}, fr(11'h08c, eb));
		m.send(fr(11'h60c, 64'h4003100100000000));
		expect_tx({w, " hist"}, fr(11'h58c, hb));
	endtask : ev_hist
	task t_emcy;
		ev_hist("q4", 8'h03, 32'h40, 64'h03ff010340000000, 64'h4203100140000000);
		ev_hist("i12", 8'h0e, 32'h10000, 64'h03ff010e00000100, 64'h4203100100000100);
	endtask : t_emcy
	// Current errors come back inverted; the far side stalls the first one.
	task t_cur;
		module_diag[3] = 32'h04000040;
		module_diag[14] = 32'h04010000;
		stall = 1;
		m.send(fr(11'h60c, 64'h4000310400000000));
		step(5);
		chk("stall hold", 75'h1, 75'(tx_valid));
		stall = 0;
		expect_tx("cur q4", fr(11'h58c, 64'h42003104bffffffb));
		m.send(fr(11'h60c, 64'h4000310f00000000));
		expect_tx("cur i12", fr(11'h58c, 64'h4200310ffffffefb));
	endtask : t_cur
	task t_refuse;
		int k;
		k = m.n_got;
		m.send(fr(11'h60d, 64'h4003100100000000));
		m.send(fr(11'h60c, 64'h2303100100000000));
		m.send(fr(11'h60c, 64'h4000310000000000));
		m.send(fr(11'h60c, 64'h4000311100000000));
		step(6);
		chk("refused", 75'(k), 75'(m.n_got));
	endtask : t_refuse
	task t_clear;
		all_errors_cleared = 1;
		step(1);
		all_errors_cleared = 0;
		expect_tx("clear", fr(11'h08c, 64'h0));
	endtask : t_clear
	task t_led;
		logic r, g, o;
		config_pending = 1;
		{r, g, o} = 3'h0;
		step(2);
		repeat (12)
		begin
			step(1);
			r |= mod_led === cdr_pkg::CDR_LED_RED;
			g |= mod_led === cdr_pkg::CDR_LED_GREEN;
			o |= mod_led === cdr_pkg::CDR_LED_OFF;
		end
		chk("flash", 75'h5, 75'({r, g, o}));
		config_pending = 0;
		{r, g, o} = 3'h0;
		step(2);
		repeat (12)
		begin
			step(1);
			r |= mod_led === cdr_pkg::CDR_LED_RED;
			g |= mod_led === cdr_pkg::CDR_LED_GREEN;
			o |= net_led !== cdr_pkg::CDR_LED_GREEN;
		end
		chk("pdo wait", 75'h6, 75'({r, g, o}));
		pdo_seen = 1;
		bus_ok = 0;
		step(3);
		chk("module led run", 75'(cdr_pkg::CDR_LED_GREEN), 75'(mod_led));
		chk("network led off", 75'(cdr_pkg::CDR_LED_OFF), 75'(net_led));
		chk("supply led", 75'h1, 75'(supply_led));
	endtask : t_led
	task give_verdict;
		if (n_fail == 0 && tests_run > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : give_verdict
	// Main sequence after a 20 cycle reset.
	initial
	begin
		step(20);
		reset = 0;
		t_emcy;
		t_cur;
		t_refuse;
		t_clear;
		t_led;
		give_verdict;
	end
	// A hang is cut short well past the expected run length.
	initial
	begin
		#200000;
		n_fail++;
		give_verdict;
	end
endmodule : canopen_diag_responder_tb_top
